// ---- verilog/wdt_pkg.sv ----
// Package: constants and carrier types for the watchdog unit
package wdt_pkg;
  localparam int unsigned CNT_W          = 10;
  localparam int unsigned OSC_FREQ_HZ    = 32768;
  localparam int unsigned TICK_FREQ_HZ   = 256;
  localparam int unsigned TIMEOUT_PERIODS = 131072;
  localparam int unsigned TIMEOUT_TICKS  = TIMEOUT_PERIODS / (OSC_FREQ_HZ / TICK_FREQ_HZ);
  localparam logic [3:0]  RUN_STOP_CODE  = 4'hA;
  localparam logic        MODE_NMI       = 1'h0;
  localparam logic        MODE_RESET     = 1'h1;
  localparam int unsigned CTL_CLR_BIT    = 4;
  localparam int unsigned CTL_RUN_LSB    = 0;
  localparam int unsigned ST_MODE_BIT    = 1;
  localparam int unsigned ST_FLAG_BIT    = 0;
  localparam logic [7:0]  RD_ZERO        = 8'h00;

  typedef struct packed {
    logic       counter_clear_bit;
    logic [3:0] run_stop_code;
  } watchdog_control_reg_wr_t;

  typedef struct packed {
    logic nmi;
    logic rst;
  } wdt_event_t;
endpackage

// ---- verilog/wdt_watchdog_unit.sv ----
// Watchdog unit: 10-bit tick counter raising an NMI or reset pulse on overflow
`timescale 1ns/1ns
module wdt_watchdog_unit #(
  parameter int unsigned CNT_W = wdt_pkg::CNT_W
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  input  wire logic               i_regulated_256hz_clock,
  input  wire logic               i_sleep,
  input  wire logic               i_ctl_wr,
  input  wire wdt_pkg::watchdog_control_reg_wr_t i_ctl_wdata,
  input  wire logic               i_st_wr,
  input  wire logic               i_st_mode_wdata,
  output logic [7:0]              o_ctl_rdata,
  output logic [7:0]              o_st_rdata,
  output logic                    o_running,
  output logic [CNT_W-1:0]        o_count,
  output logic                    o_nmi,
  output logic                    o_cpu_reset
);

  // Overflow must land on the documented timeout; another width would stretch or cut it
  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
    $error("CNT_W out of range");
  end
  if (CNT_W == wdt_pkg::CNT_W && (32'h1 << CNT_W) != wdt_pkg::TIMEOUT_TICKS) begin : g_bad_period
    $error("CNT_W does not match the timeout");
  end

  // Two-stage synchroniser; only stage two and later feed the edge detector
  logic sync1_r, sync2_r, sync3_r;
  logic sync1_nxt, sync2_nxt, sync3_nxt;
  always_comb begin
    sync1_nxt = i_regulated_256hz_clock;
    sync2_nxt = sync1_r;
    sync3_nxt = sync2_r;
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      sync3_r <= sync3_nxt;
    end
  end

  logic tick;
  logic run;
  logic clr;
  logic ovf;
  // Rising edge of the 256 Hz clock, gated in sleep; halt does not gate it
  assign tick = sync2_r && !sync3_r && !i_sleep;
  assign clr  = i_ctl_wr && i_ctl_wdata.counter_clear_bit;

  logic [3:0]       code_r, code_nxt;
  logic             mode_r, mode_nxt;
  logic             flag_r, flag_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             nmi_r, nmi_nxt;
  logic             rst_r, rst_nxt;

  assign run = (code_r != wdt_pkg::RUN_STOP_CODE);
  // Overflow is the wrap from all ones; the count wraps to zero and keeps going
  assign ovf = run && tick && (cnt_r == {CNT_W{1'b1}});

  always_comb begin
    code_nxt = code_r;
    mode_nxt = mode_r;
    flag_nxt = flag_r;
    cnt_nxt  = cnt_r;
    if (i_ctl_wr) begin
      code_nxt = i_ctl_wdata.run_stop_code;
    end
    if (i_st_wr) begin
      mode_nxt = i_st_mode_wdata;
    end
    // Clear beats a tick so the new period is a full one
    if (clr) begin
      cnt_nxt = '0;
    end else if (run && tick) begin
      cnt_nxt = cnt_r + 1'b1;
    end
    // Set beats clear: an overflow landing on a clear is not lost
    if (ovf) begin
      flag_nxt = 1'b1;
    end else if (clr) begin
      flag_nxt = 1'b0;
    end
    nmi_nxt = ovf && (mode_r == wdt_pkg::MODE_NMI);
    rst_nxt = ovf && (mode_r == wdt_pkg::MODE_RESET);
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      code_r <= wdt_pkg::RUN_STOP_CODE;
      mode_r <= wdt_pkg::MODE_NMI;
      flag_r <= 1'b0;
      cnt_r  <= '0;
      nmi_r  <= 1'b0;
      rst_r  <= 1'b0;
    end else begin
      code_r <= code_nxt;
      mode_r <= mode_nxt;
      flag_r <= flag_nxt;
      cnt_r  <= cnt_nxt;
      nmi_r  <= nmi_nxt;
      rst_r  <= rst_nxt;
    end
  end

  // Clear bit is write-only, so bit 4 always reads 0
  always_comb begin
    o_ctl_rdata = wdt_pkg::RD_ZERO;
    o_ctl_rdata[wdt_pkg::CTL_RUN_LSB +: 4] = code_r;
    o_st_rdata  = wdt_pkg::RD_ZERO;
    o_st_rdata[wdt_pkg::ST_MODE_BIT] = mode_r;
    o_st_rdata[wdt_pkg::ST_FLAG_BIT] = flag_r;
  end

  assign o_running   = run;
  assign o_count     = cnt_r;
  assign o_nmi       = nmi_r;
  assign o_cpu_reset = rst_r;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  chk_stop_holds: assert property (
    (!run && !clr) |=> (cnt_r == $past(cnt_r)))
    else $error("counter moved while stopped");
  chk_sleep_holds: assert property (
    (i_sleep && !clr) |=> $stable(cnt_r))
    else $error("counter moved in sleep");
  chk_tick_incr: assert property (
    (run && tick && !clr) |=> (cnt_r == $past(cnt_r) + 1'b1))
    else $error("counter missed a tick");
  chk_clear_zero: assert property (
    clr |=> (cnt_r == '0))
    else $error("clear did not zero counter");
  chk_nmi_mode: assert property (
    (ovf && mode_r == wdt_pkg::MODE_NMI) |=> (o_nmi && !o_cpu_reset && flag_r))
    else $error("nmi overflow wrong");
  chk_reset_mode: assert property (
    (ovf && mode_r == wdt_pkg::MODE_RESET) |=> (o_cpu_reset && !o_nmi))
    else $error("reset overflow wrong");
  chk_single_pulse: assert property (
    (o_nmi || o_cpu_reset) |=> !(o_nmi || o_cpu_reset))
    else $error("overflow pulse too long");
  chk_flag_clear: assert property (
    (clr && !ovf) |=> !flag_r)
    else $error("flag survived clear");
  chk_pulse_cause: assert property (
    o_nmi |-> ($past(cnt_r) == {CNT_W{1'b1}} && cnt_r == '0))
    else $error("pulse without wrap");
  chk_ctl_read: assert property (
    (o_ctl_rdata[7:4] == 4'h0) && (o_st_rdata[7:2] == 6'h00))
    else $error("reserved bits read nonzero");

  // Register writes land one cycle after the strobe
  chk_code_write: assert property (
    i_ctl_wr |=> (code_r == $past(i_ctl_wdata.run_stop_code)))
    else $error("run code write lost");
  chk_mode_write: assert property (
    i_st_wr |=> (mode_r == $past(i_st_mode_wdata)))
    else $error("action select write lost");
  chk_mode_hold: assert property (
    !i_st_wr |=> $stable(mode_r))
    else $error("action select moved without write");

  // The flag only moves on overflow or clear, so software can still read it late
  chk_flag_hold: assert property (
    (!ovf && !clr) |=> $stable(flag_r))
    else $error("status flag moved on its own");
  chk_reset_cause: assert property (
    o_cpu_reset |-> ($past(cnt_r) == {CNT_W{1'b1}} && $past(mode_r) == wdt_pkg::MODE_RESET))
    else $error("reset pulse without wrap");
  chk_nmi_cause: assert property (
    o_nmi |-> ($past(mode_r) == wdt_pkg::MODE_NMI))
    else $error("nmi pulse in reset mode");
  // Ticks come from a synced edge, so two in a row would mean a broken detector
  chk_tick_spacing: assert property (
    tick |=> !tick)
    else $error("tick lasted two cycles");
  chk_one_action: assert property (
    !(o_nmi && o_cpu_reset))
    else $error("nmi and reset together");
  chk_sleep_quiet: assert property (
    i_sleep |=> !(o_nmi || o_cpu_reset))
    else $error("overflow pulse out of sleep");

  // Main scenarios worth seeing at least once
  cov_nmi:   cover property (o_nmi);
  cov_reset: cover property (o_cpu_reset);
  cov_clear_on_ovf: cover property (clr && ovf);
  cov_sleep_tick:   cover property (sync2_r && !sync3_r && i_sleep && run);
  cov_stop_write:   cover property (i_ctl_wr && run && !clr);

endmodule // wdt_watchdog_unit

// ---- tb/wdt_cpu_model.sv ----
// CPU core model: counts the cycles seen on the NMI and reset lines
`timescale 1ns/1ns
module wdt_cpu_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_nmi,
  input  wire logic       i_cpu_reset,
  output logic      [7:0] o_nmi_cnt,
  output logic      [7:0] o_rst_cnt
);
  // Counts high cycles, not edges, so a stretched pulse shows as extra counts
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_nmi_cnt <= 8'h00;
      o_rst_cnt <= 8'h00;
    end else begin
      o_nmi_cnt <= o_nmi_cnt + 8'(i_nmi);
      o_rst_cnt <= o_rst_cnt + 8'(i_cpu_reset);
    end
  end
endmodule // wdt_cpu_model

// ---- tb/tb.sv ----
// Testbench: drives watchdog register writes and ticks, checks counts and pulses
`timescale 1ns/1ns
module tb;
  logic clk = 0, rst_b = 0, t = 0, slp = 0, cw = 0, sw = 0, sm = 0, run, nmi, cres;
  wdt_pkg::watchdog_control_reg_wr_t cd = '0;
  logic [7:0] crd, srd, nc, rc;
  logic [9:0] cnt;
  int fail_count = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  wdt_watchdog_unit uut (.i_clk(clk), .i_rst_b(rst_b), .i_regulated_256hz_clock(t),
    .i_sleep(slp), .i_ctl_wr(cw), .i_ctl_wdata(cd), .i_st_wr(sw), .i_st_mode_wdata(sm),
    .o_ctl_rdata(crd), .o_st_rdata(srd), .o_running(run), .o_count(cnt), .o_nmi(nmi),
    .o_cpu_reset(cres));
  wdt_cpu_model cpu (.i_clk(clk), .i_rst_b(rst_b), .i_nmi(nmi), .i_cpu_reset(cres),
    .o_nmi_cnt(nc), .o_rst_cnt(rc));
  task chk(input string n, input logic [9:0] e, input logic [9:0] g);
    #1;
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task wr_ctl(input logic c, input logic [3:0] r);
    @(posedge clk) begin
      cw <= 1'b1;
      cd <= {c, r};
    end
    @(posedge clk) cw <= 1'b0;
    @(posedge clk);
  endtask
  task wr_st(input logic m);
    @(posedge clk) begin
      sw <= 1'b1;
      sm <= m;
    end
    @(posedge clk) sw <= 1'b0;
    @(posedge clk);
  endtask
  // Holds each level at least 4 cycles, longer than the 2-stage sync chain
  task tick(input int n);
    repeat (n) begin
      @(posedge clk) t <= 1'b1;
      repeat (4) @(posedge clk);
      t <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    chk("ctl", 10'h00A, 10'(crd));
    chk("st", 10'h000, 10'(srd));
    tick(2);
    chk("count", 10'h000, cnt);
    $display("reset test done");
    wr_ctl(1'b1, 4'h0);
    chk("running", 10'h001, 10'(run));
    tick(3);
    chk("count", 10'h003, cnt);
    @(posedge clk) slp <= 1'b1;
    tick(2);
    chk("count", 10'h003, cnt);
    @(posedge clk) slp <= 1'b0;
    tick(1);
    chk("count", 10'h004, cnt);
    $display("count test done");
    wr_ctl(1'b1, 4'h0);
    chk("count", 10'h000, cnt);
    chk("ctl", 10'h000, 10'(crd));
    tick(1023);
    chk("nmi", 10'h000, 10'(nc));
    tick(1);
    chk("nmi", 10'h001, 10'(nc));
    chk("st", 10'h001, 10'(srd));
    chk("count", 10'h000, cnt);
    tick(1);
    chk("count", 10'h001, cnt);
    $display("nmi test done");
    wr_ctl(1'b1, 4'h5);
    chk("st", 10'h000, 10'(srd));
    wr_st(1'b1);
    chk("st", 10'h002, 10'(srd));
    tick(1027);
    chk("reset", 10'h001, 10'(rc));
    chk("nmi", 10'h001, 10'(nc));
    chk("st", 10'h003, 10'(srd));
    wr_ctl(1'b0, 4'hA);
    chk("running", 10'h000, 10'(run));
    tick(2);
    chk("count", 10'h003, cnt);
    $display("reset mode test done");
    complete_run;
  end
endmodule // tb
